// ===== rtl/tsi_regs.vh
`ifndef TSI_REGS_VH
`define TSI_REGS_VH
// Function
// R1 - field output high with field, low otherwise
// R2 - wake-up pulse on battery-to-field changeover
// R3 - auto mode: field above on, battery below off
// R4 - field-on must persist for switch delay first
// R5 - field loss drives a reset pulse outward
// R6 - serial command disables or enables auto switching
// R7 - disabled on battery: no field load drawn
// R8 - data line changes only while clock low
// R9 - data edge during clock high is framing
// R10 - stop is falling data edge, clock high
// R11 - start leaves standby, stop returns to it
// R12 - ninth clock carries receiver acknowledge low
// R13 - no master acknowledge ends transmission, receive
// R14 - master ends reads with nack then stop
// R15 - control byte: row, two mode bits, direction
// R16 - direction bit zero write, one read
// R17 - standby releases data line to pull-up
// R18 - store of 32 rows by 16 bits
// R19 - writes of one or two bytes, reads unlimited
// R20 - special control bytes steer modulator or power
// R21 - master makes clock; data line bidirectional
// R22 - recovered carrier clock driven out
// R23 - mode bits pick high or low byte first
// R24 - programming busy: no acknowledge, inputs ignored
// R25 - master forces known state: nack read, stop
// R26 - edges found on sampled clock, pauses tolerated

// ******
// clock and timing
// ******
`define TSI_PROG_CYCLES 20'hf4240
`define TSI_BFS_CYCLES 16'h03e8
`define TSI_RSTP_CYCLES 16'h00c8

// ******
// synchroniser bit positions
// ******
`define TSI_SYNC_W 8
`define TSI_I_SCL 0
`define TSI_I_SDA 1
`define TSI_I_FIELD 2
`define TSI_I_ABOVE_ON 3
`define TSI_I_BELOW_OFF 4
`define TSI_I_CARRIER 5
`define TSI_I_DAMP 6
`define TSI_I_RSTLINE 7
`define TSI_SYNC_RST 8'h83

// ******
// serial states
// ******
`define TSI_S_IDLE 3'h0
`define TSI_S_CTRL 3'h1
`define TSI_S_CACK 3'h2
`define TSI_S_WDATA 3'h3
`define TSI_S_WACK 3'h4
`define TSI_S_TX 3'h5
`define TSI_S_MACK 3'h6
`define TSI_S_WAIT 3'h7

// ******
// control byte layout and codes
// ******
`define TSI_C_DIR 0
`define TSI_C_MLO 1
`define TSI_C_MHI 2
`define TSI_C_ROW_LO 3
`define TSI_C_ROW_HI 7
`define TSI_SP_MASK 8'hf7
`define TSI_SP_BIPHASE 8'hc7
`define TSI_SP_MANCH 8'hd7
`define TSI_SP_PM_OFF 8'he7
`define TSI_SP_PM_ON 8'hf7
`define TSI_MOD_NONE 2'h0
`define TSI_MOD_BIPHASE 2'h1
`define TSI_MOD_MANCH 2'h2
`define TSI_LAST_BIT 3'h7
`define TSI_MAX_WBYTES 2'h2
`endif

// ===== rtl/tsi_mem.v
`timescale 1ns/1ps
// ******
// row store with registered read
// ******
module tsi_mem #(
  parameter DW = 16,
  parameter AW = 5
) (
  // clock
  input wire clk,
  // write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // read port
  input wire re,
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata_r
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1]; // storage rows

  // write and registered read
  always @(posedge clk) begin
    if (we) begin
      mem_r[waddr] <= wdata; // R18
    end
    if (re) begin
      rdata_r <= mem_r[raddr];
    end
  end
endmodule // tsi_mem

// ===== rtl/tsi_fifo.v
`timescale 1ns/1ps
// ******
// small word buffer with valid/ready
// ******
module tsi_fifo #(
  parameter W = 16,
  parameter AW = 1
) (
  // clock and reset
  input wire clk,
  input wire rst,
  input wire flush,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  localparam DEPTH = 1 << AW;
  reg [W-1:0] buf_r [0:DEPTH-1]; // entries
  reg [AW-1:0] wp_r; // write pointer
  reg [AW-1:0] rp_r; // read pointer
  reg [AW:0] cnt_r; // fill level
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = buf_r[rp_r];

  // pointer and level update
  always @(posedge clk) begin
    if (rst || flush) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rp_r <= rp_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_r <= cnt_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // entry store
  always @(posedge clk) begin
    if (push) begin
      buf_r[wp_r] <= in_data;
    end
  end
endmodule // tsi_fifo

// ===== rtl/tsi_top.v
`timescale 1ns/1ps
`include "tsi_regs.vh"
// ******
// transponder serial interface top
// ******
module tsi_top #(
  parameter [19:0] PROG_CYCLES = `TSI_PROG_CYCLES,
  parameter [15:0] BFS_CYCLES = `TSI_BFS_CYCLES,
  parameter [15:0] RSTP_CYCLES = `TSI_RSTP_CYCLES,
  parameter STOP_ON_FALL = 1
) (
  // clock and reset
  input wire CLK,
  input wire RST,
  // serial bus
  input wire SCL,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  // analog front end levels
  input wire FIELD_DETECT_IN,
  input wire COIL_ABOVE_ON_IN,
  input wire COIL_BELOW_OFF_IN,
  input wire CARRIER_IN,
  input wire DAMPING_CONTROL_IN,
  // reset line
  input wire BIDIR_RESET_LINE_IN,
  output wire BIDIR_RESET_LINE_OUT,
  output wire BIDIR_RESET_LINE_OE,
  // status and control outputs
  output wire FIELD_PRESENT_OUT,
  output wire WAKEUP_PULSE,
  output wire SUPPLY_FROM_FIELD,
  output wire FIELD_LOAD_EN,
  output wire AUTO_SWITCH_EN,
  output wire [1:0] MOD_MODE,
  output wire DAMP_OUT,
  output wire RECOVERED_CARRIER_CLOCK,
  output wire BUSY
);
  // ******
  // helpers
  // ******
  function [7:0] pick_byte;
    input [15:0] w;
    input hi;
    begin
      pick_byte = hi ? w[15:8] : w[7:0];
    end
  endfunction

  function is_code;
    input [7:0] c;
    input [7:0] code;
    begin
      is_code = ((c & `TSI_SP_MASK) == code);
    end
  endfunction

  // pull the line when the first bit to send is low
  function low_msb;
    input [15:0] w;
    input hi;
    begin
      low_msb = ~(hi ? w[15] : w[7]);
    end
  endfunction

  // ******
  // input synchronisers
  // ******
  reg [`TSI_SYNC_W-1:0] sync1_r; // first stage, read only by second
  reg [`TSI_SYNC_W-1:0] sync2_r; // second stage
  reg scl_d_r; // previous sampled clock
  reg sda_d_r; // previous sampled data
  wire [`TSI_SYNC_W-1:0] raw_in = {BIDIR_RESET_LINE_IN, DAMPING_CONTROL_IN, CARRIER_IN, COIL_BELOW_OFF_IN,
    COIL_ABOVE_ON_IN, FIELD_DETECT_IN, SDA_IN, SCL};

  // two-flop sampling of every outside level
  always @(posedge CLK) begin
    if (RST) begin
      sync1_r <= `TSI_SYNC_RST;
      sync2_r <= `TSI_SYNC_RST;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= raw_in; // R26
      sync2_r <= sync1_r;
      scl_d_r <= sync2_r[`TSI_I_SCL];
      sda_d_r <= sync2_r[`TSI_I_SDA];
    end
  end

  wire scl = sync2_r[`TSI_I_SCL]; // master clock level
  wire sda = sync2_r[`TSI_I_SDA]; // wire level
  wire scl_rise = scl & ~scl_d_r; // R21
  wire scl_fall = ~scl & scl_d_r;
  wire sda_edge = scl & scl_d_r & (sda ^ sda_d_r); // R9
  wire start_det = sda_edge & (sda == (STOP_ON_FALL != 0)); // R10
  wire stop_det = sda_edge & (sda != (STOP_ON_FALL != 0)); // R10
  wire srst = RST | ~sync2_r[`TSI_I_RSTLINE]; // serial reset, also from line

  // ******
  // serial state machine
  // ******
  reg [2:0] state_r; // serial state
  reg [2:0] bit_cnt_r; // bit in byte
  reg byte_done_r; // eighth bit seen
  reg [7:0] shift_r; // shift register
  reg [7:0] ctrl_r; // held control byte
  reg special_r; // special command active
  reg half_r; // second byte of word
  reg [1:0] data_cnt_r; // written data bytes
  reg mack_r; // master acknowledged
  reg sda_oe_r; // drive line low
  reg [15:0] word_r; // word buffer
  reg auto_en_r; // automatic switching on
  reg [1:0] mod_mode_r; // modulator mode
  reg busy_r; // programming in progress
  wire [7:0] shift_in = {shift_r[6:0], sda};
  wire hi_first = ctrl_r[`TSI_C_MHI]; // R23
  wire in_sp = (shift_r[`TSI_C_MHI:`TSI_C_DIR] == 3'h7) & (shift_r[7:6] == 2'h3);
  wire ctrl_end = (state_r == `TSI_S_CTRL) & scl_fall & byte_done_r;
  wire ctrl_accept = ctrl_end & ~busy_r & ~in_sp;
  wire cack_end = (state_r == `TSI_S_CACK) & scl_fall;
  wire next_word = (state_r == `TSI_S_MACK) & scl_fall & mack_r & half_r;
  wire fifo_pop = (cack_end & ~special_r) | next_word;
  wire [15:0] fifo_out;
  wire in_write = (state_r == `TSI_S_WDATA) | (state_r == `TSI_S_WACK);
  wire prog_start = stop_det & in_write & (data_cnt_r != 2'h0) & ~busy_r;

  // framing, acknowledge and byte handling
  always @(posedge CLK) begin
    if (srst) begin
      state_r <= `TSI_S_IDLE;
      bit_cnt_r <= 3'h0;
      byte_done_r <= 1'b0;
      shift_r <= 8'h00;
      ctrl_r <= 8'h00;
      special_r <= 1'b0;
      half_r <= 1'b0;
      data_cnt_r <= 2'h0;
      mack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      word_r <= 16'h0000;
      auto_en_r <= 1'b1;
      mod_mode_r <= `TSI_MOD_NONE;
    end else if (stop_det) begin
      state_r <= `TSI_S_IDLE; // R11
      sda_oe_r <= 1'b0; // R17
    end else if (start_det) begin
      state_r <= `TSI_S_CTRL; // R11
      bit_cnt_r <= 3'h0;
      byte_done_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        `TSI_S_CTRL, `TSI_S_WDATA: begin
          // receive a byte on rising clock
          if (scl_rise) begin
            shift_r <= shift_in;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            byte_done_r <= (bit_cnt_r == `TSI_LAST_BIT);
          end else if (scl_fall && byte_done_r) begin
            byte_done_r <= 1'b0;
            if (state_r == `TSI_S_CTRL) begin
              ctrl_r <= shift_r; // R15
              special_r <= in_sp;
              if (busy_r) begin
                state_r <= `TSI_S_WAIT; // R24
              end else begin
                state_r <= `TSI_S_CACK;
                sda_oe_r <= 1'b1; // R12
                if (is_code(shift_r, `TSI_SP_BIPHASE)) begin
                  mod_mode_r <= `TSI_MOD_BIPHASE; // R20
                end else if (is_code(shift_r, `TSI_SP_MANCH)) begin
                  mod_mode_r <= `TSI_MOD_MANCH; // R20
                end else if (is_code(shift_r, `TSI_SP_PM_OFF)) begin
                  auto_en_r <= 1'b0; // R6
                end else if (is_code(shift_r, `TSI_SP_PM_ON)) begin
                  auto_en_r <= 1'b1; // R6
                end
              end
            end else if (data_cnt_r != `TSI_MAX_WBYTES) begin
              // overwrite the half chosen by order and count
              if (hi_first ^ data_cnt_r[0]) begin
                word_r[15:8] <= shift_r; // R23
              end else begin
                word_r[7:0] <= shift_r;
              end
              data_cnt_r <= data_cnt_r + 2'h1; // R19
              state_r <= `TSI_S_WACK;
              sda_oe_r <= ~special_r; // R12
            end else begin
              // refused byte: left unacknowledged, stop still programs
              state_r <= `TSI_S_WACK; // R19
            end
          end
        end
        `TSI_S_CACK: begin
          // end of acknowledge clock: pick direction
          if (scl_fall) begin
            bit_cnt_r <= 3'h0;
            if (special_r) begin
              state_r <= `TSI_S_WAIT; // R20
              sda_oe_r <= 1'b0;
            end else if (ctrl_r[`TSI_C_DIR]) begin
              word_r <= fifo_out; // R16
              shift_r <= pick_byte(fifo_out, hi_first);
              sda_oe_r <= low_msb(fifo_out, hi_first); // R8
              half_r <= 1'b0;
              state_r <= `TSI_S_TX;
            end else begin
              word_r <= fifo_out; // R16
              data_cnt_r <= 2'h0;
              sda_oe_r <= 1'b0;
              state_r <= `TSI_S_WDATA;
            end
          end
        end
        `TSI_S_WACK: begin
          // release after the acknowledge clock
          if (scl_fall) begin
            sda_oe_r <= 1'b0; // R8
            bit_cnt_r <= 3'h0;
            state_r <= `TSI_S_WDATA;
          end
        end
        `TSI_S_TX: begin
          // shift out on falling clock
          if (scl_rise) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            byte_done_r <= (bit_cnt_r == `TSI_LAST_BIT);
          end else if (scl_fall) begin
            if (byte_done_r) begin
              byte_done_r <= 1'b0;
              sda_oe_r <= 1'b0;
              state_r <= `TSI_S_MACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_oe_r <= ~shift_r[6]; // R8
            end
          end
        end
        `TSI_S_MACK: begin
          // sample master acknowledge, then next byte or stop sending
          if (scl_rise) begin
            mack_r <= ~sda; // R12
          end else if (scl_fall) begin
            if (!mack_r) begin
              state_r <= `TSI_S_WAIT; // R13 R14 R25
            end else if (!half_r) begin
              half_r <= 1'b1;
              shift_r <= pick_byte(word_r, ~hi_first);
              sda_oe_r <= low_msb(word_r, ~hi_first);
              state_r <= `TSI_S_TX;
            end else begin
              half_r <= 1'b0;
              word_r <= fifo_out; // R19
              shift_r <= pick_byte(fifo_out, hi_first);
              sda_oe_r <= low_msb(fifo_out, hi_first);
              state_r <= `TSI_S_TX;
            end
          end
        end
        default: begin
          // standby and wait: line released
          sda_oe_r <= 1'b0; // R17
        end
      endcase
    end
  end

  // ******
  // programming cycle
  // ******
  reg [19:0] prog_cnt_r; // elapsed cycles
  reg [4:0] prog_row_r; // row being written
  wire prog_we = busy_r & (prog_cnt_r == PROG_CYCLES - 20'h1);

  // busy window after a write stop
  always @(posedge CLK) begin
    if (RST) begin
      busy_r <= 1'b0;
      prog_cnt_r <= 20'h00000;
      prog_row_r <= 5'h00;
    end else if (prog_start) begin
      busy_r <= 1'b1; // R24
      prog_cnt_r <= 20'h00000;
      prog_row_r <= ctrl_r[`TSI_C_ROW_HI:`TSI_C_ROW_LO];
    end else if (busy_r) begin
      prog_cnt_r <= prog_cnt_r + 20'h00001;
      busy_r <= ~prog_we;
    end
  end

  // ******
  // read prefetch into the word buffer
  // ******
  reg [4:0] pf_addr_r; // next row to fetch
  reg pf_dec_r; // walk downward
  reg pf_run_r; // prefetch enabled
  reg pf_pend_r; // read in flight
  wire fifo_in_ready;
  wire [15:0] mem_rdata;
  wire pf_issue = pf_run_r & fifo_in_ready & ~pf_pend_r & ~prog_we & ~ctrl_accept;

  // fetch rows ahead, rolling over at the ends
  always @(posedge CLK) begin
    if (srst || stop_det) begin
      pf_addr_r <= 5'h00;
      pf_dec_r <= 1'b0;
      pf_run_r <= 1'b0;
      pf_pend_r <= 1'b0;
    end else if (ctrl_accept) begin
      pf_addr_r <= shift_r[`TSI_C_ROW_HI:`TSI_C_ROW_LO];
      pf_dec_r <= shift_r[`TSI_C_MHI]; // R23
      pf_run_r <= 1'b1;
      pf_pend_r <= 1'b0;
    end else begin
      pf_pend_r <= pf_issue;
      if (pf_issue) begin
        pf_addr_r <= pf_dec_r ? pf_addr_r - 5'h01 : pf_addr_r + 5'h01;
      end
    end
  end

  tsi_mem #(.DW(16), .AW(5)) u_mem (
    .clk(CLK),
    .we(prog_we),
    .waddr(prog_row_r),
    .wdata(word_r),
    .re(pf_issue),
    .raddr(pf_addr_r),
    .rdata_r(mem_rdata)
  );

  tsi_fifo #(.W(16), .AW(1)) u_fifo (
    .clk(CLK),
    .rst(srst),
    .flush(ctrl_accept | stop_det),
    .in_valid(pf_pend_r),
    .in_ready(fifo_in_ready),
    .in_data(mem_rdata),
    .out_valid(),
    .out_ready(fifo_pop),
    .out_data(fifo_out)
  );

  // ******
  // power management
  // ******
  reg supply_field_r; // running on field supply
  reg [15:0] bfs_cnt_r; // filter count
  reg wake_r; // wake-up pulse
  reg [15:0] rstp_cnt_r; // outgoing reset length
  reg field_out_r; // gap/field level
  reg carrier_r; // recovered carrier
  reg damp_r; // damping drive
  wire above_on = sync2_r[`TSI_I_ABOVE_ON];
  wire below_off = sync2_r[`TSI_I_BELOW_OFF];

  // filtered switching between battery and field
  always @(posedge CLK) begin
    if (RST) begin
      supply_field_r <= 1'b0;
      bfs_cnt_r <= 16'h0000;
      wake_r <= 1'b0;
      rstp_cnt_r <= 16'h0000;
    end else begin
      wake_r <= 1'b0;
      if (rstp_cnt_r != 16'h0000) begin
        rstp_cnt_r <= rstp_cnt_r - 16'h0001;
      end
      if (!auto_en_r) begin
        supply_field_r <= 1'b0; // R6
        bfs_cnt_r <= 16'h0000;
      end else if (!supply_field_r) begin
        if (!above_on) begin
          bfs_cnt_r <= 16'h0000; // R4
        end else if (bfs_cnt_r == BFS_CYCLES - 16'h0001) begin
          supply_field_r <= 1'b1; // R3
          wake_r <= 1'b1; // R2
          bfs_cnt_r <= 16'h0000;
        end else begin
          bfs_cnt_r <= bfs_cnt_r + 16'h0001; // R4
        end
      end else if (below_off) begin
        supply_field_r <= 1'b0; // R3
        rstp_cnt_r <= RSTP_CYCLES; // R5
      end
    end
  end

  // registered pass-through of front end levels
  always @(posedge CLK) begin
    if (RST) begin
      field_out_r <= 1'b0;
      carrier_r <= 1'b0;
      damp_r <= 1'b0;
    end else begin
      field_out_r <= sync2_r[`TSI_I_FIELD]; // R1
      carrier_r <= sync2_r[`TSI_I_CARRIER]; // R22
      damp_r <= sync2_r[`TSI_I_DAMP]; // R7
    end
  end

  // ******
  // outputs
  // ******
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_r;
  assign BIDIR_RESET_LINE_OUT = 1'b0;
  assign BIDIR_RESET_LINE_OE = (rstp_cnt_r != 16'h0000); // R5
  assign FIELD_PRESENT_OUT = field_out_r | wake_r; // R1 R2
  assign WAKEUP_PULSE = wake_r;
  assign SUPPLY_FROM_FIELD = supply_field_r;
  assign FIELD_LOAD_EN = supply_field_r; // R7
  assign AUTO_SWITCH_EN = auto_en_r;
  assign MOD_MODE = mod_mode_r;
  assign DAMP_OUT = damp_r;
  assign RECOVERED_CARRIER_CLOCK = carrier_r;
  assign BUSY = busy_r;
endmodule // tsi_top

// ===== verification/tsi_assertions.sv
`timescale 1ns/1ps
// ******
// port checks: front end lag, power switching and serial pin
// ******
module tsi_assertions #(
  parameter [15:0] BFS_CYCLES = 16'h03e8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // serial bus
  input wire logic SCL,
  input wire logic SDA_OE,
  // front end levels
  input wire logic COIL_ABOVE_ON_IN,
  input wire logic CARRIER_IN,
  input wire logic DAMPING_CONTROL_IN,
  // status outputs
  input wire logic WAKEUP_PULSE,
  input wire logic SUPPLY_FROM_FIELD,
  input wire logic FIELD_LOAD_EN,
  input wire logic AUTO_SWITCH_EN,
  input wire logic BIDIR_RESET_LINE_OE,
  input wire logic RECOVERED_CARRIER_CLOCK,
  input wire logic DAMP_OUT,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  logic [15:0] above_cnt_r; // cycles the field-on level has held
  // count the run of field-on, saturating
  always_ff @(posedge CLK) begin
    if (RST || !COIL_ABOVE_ON_IN) above_cnt_r <= 16'h0000;
    else if (above_cnt_r != 16'hffff) above_cnt_r <= above_cnt_r + 16'h0001;
  end
  a_carrier_delay:
    assert property (!$past(RST) && !$past(RST, 2) && !$past(RST, 3)
      |-> RECOVERED_CARRIER_CLOCK == $past(CARRIER_IN, 3) && DAMP_OUT == $past(DAMPING_CONTROL_IN, 3))
      else $error("front end lag wrong");
  a_load_follows:
    assert property (!AUTO_SWITCH_EN [*2] |-> !FIELD_LOAD_EN) else $error("field load while auto off");
  a_auto_off_battery:
    assert property (!AUTO_SWITCH_EN [*2] |-> !SUPPLY_FROM_FIELD) else $error("field supply while auto off");
  a_wake_single:
    assert property (WAKEUP_PULSE |=> !WAKEUP_PULSE) else $error("wake pulse too long");
  a_wake_on_switch:
    assert property ($rose(SUPPLY_FROM_FIELD) |-> $past(WAKEUP_PULSE) or ##[0:1] WAKEUP_PULSE)
      else $error("no wake pulse on switch");
  a_switch_delay:
    assert property ($rose(SUPPLY_FROM_FIELD) |-> above_cnt_r >= BFS_CYCLES + 16'h0001)
      else $error("field supply before delay");
  a_loss_reset:
    assert property ($fell(SUPPLY_FROM_FIELD) && AUTO_SWITCH_EN && $past(AUTO_SWITCH_EN)
      |-> ##[0:2] BIDIR_RESET_LINE_OE) else $error("no reset on field loss");
  a_reset_length:
    assert property ($rose(BIDIR_RESET_LINE_OE) |-> BIDIR_RESET_LINE_OE [*8]) else $error("reset pulse short");
  a_sda_clock_low:
    assert property ($changed(SDA_OE) |-> !SCL) else $error("data pin moved with clock high");
  a_busy_quiet:
    assert property (BUSY |-> !SDA_OE) else $error("data pin driven while busy");
endmodule // tsi_assertions

bind tsi_top tsi_assertions #(.BFS_CYCLES(BFS_CYCLES)) tsi_chk_i (
  .CLK(CLK), .RST(RST), .SCL(SCL), .SDA_OE(SDA_OE), .COIL_ABOVE_ON_IN(COIL_ABOVE_ON_IN),
  .CARRIER_IN(CARRIER_IN), .DAMPING_CONTROL_IN(DAMPING_CONTROL_IN), .DAMP_OUT(DAMP_OUT),
  .WAKEUP_PULSE(WAKEUP_PULSE), .SUPPLY_FROM_FIELD(SUPPLY_FROM_FIELD),
  .FIELD_LOAD_EN(FIELD_LOAD_EN), .AUTO_SWITCH_EN(AUTO_SWITCH_EN), .BIDIR_RESET_LINE_OE(BIDIR_RESET_LINE_OE),
  .RECOVERED_CARRIER_CLOCK(RECOVERED_CARRIER_CLOCK), .BUSY(BUSY));

// ===== verification/tsi_host_model.sv
`timescale 1ns/1ps
// ******
// serial master: makes the clock, 160 ns bits
// ******
module tsi_host_model (
  // system clock for timing
  input wire logic clk,
  // device side of the wire
  input wire logic sda_oe,
  // bus lines
  output logic scl,
  output wire logic sda
);
  logic pull; // master pulls the wire low
  assign sda = !(pull || sda_oe === 1'b1); // pull-up holds a released wire high
  initial begin
    scl = 1'b0; // clock stands low between frames
    pull = 1'b0;
  end
  // half a bit period
  task automatic h;
    repeat (8) @(negedge clk);
  endtask
  // data rises while clock high
  task automatic start;
    pull = 1'b1; h; scl = 1'b1; h; pull = 1'b0; h; scl = 1'b0;
  endtask
  // data falls while clock high, then wire released with clock low
  task automatic stop;
    pull = 1'b0; h; scl = 1'b1; h; pull = 1'b1; h; scl = 1'b0; h; pull = 1'b0; h;
  endtask
  // msb first, data moved only with clock low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      pull = !b[i]; h; scl = 1'b1; h; scl = 1'b0;
    end
    pull = 1'b0; h; scl = 1'b1; h; ack = !sda; scl = 1'b0;
  endtask
  // read a byte, then acknowledge or not
  task automatic rbyte(output logic [7:0] b, input logic nack);
    pull = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      h; scl = 1'b1; h; b[i] = sda; scl = 1'b0;
    end
    pull = !nack; h; scl = 1'b1; h; scl = 1'b0;
  endtask
endmodule // tsi_host_model

// ===== verification/tsi_top_tb.sv
`timescale 1ns/1ps
module tsi_top_tb;
  logic CLK = 1'b0, RST = 1'b1, ack;
  logic FIELD_DETECT_IN, COIL_ABOVE_ON_IN, COIL_BELOW_OFF_IN, CARRIER_IN, DAMPING_CONTROL_IN;
  wire SCL, SDA_IN, SDA_OE, RST_OE, PRESENT, WAKE, SUPPLY, LOAD, AUTO, BUSY;
  wire [1:0] MOD_MODE;
  wire RST_IN = !(RST_OE === 1'b1); // reset wire with pull-up
  int err_count = 0, comparisons = 0, t, j, k;
  logic [7:0] b, d [3];
  logic [15:0] mem [32]; // expected store contents
  logic [4:0] r;
  logic [7:0] sp [4] = '{8'hc7, 8'hd7, 8'he7, 8'hf7};
  initial forever #5 CLK = !CLK;
  tsi_top #(.PROG_CYCLES(20'h00258), .BFS_CYCLES(16'h0014), .RSTP_CYCLES(16'h000a)) uut (
    .CLK(CLK), .RST(RST), .SCL(SCL), .SDA_IN(SDA_IN), .SDA_OUT(), .SDA_OE(SDA_OE),
    .FIELD_DETECT_IN(FIELD_DETECT_IN), .COIL_ABOVE_ON_IN(COIL_ABOVE_ON_IN),
    .COIL_BELOW_OFF_IN(COIL_BELOW_OFF_IN), .CARRIER_IN(CARRIER_IN), .DAMPING_CONTROL_IN(DAMPING_CONTROL_IN),
    .BIDIR_RESET_LINE_IN(RST_IN), .BIDIR_RESET_LINE_OUT(), .BIDIR_RESET_LINE_OE(RST_OE),
    .FIELD_PRESENT_OUT(PRESENT), .WAKEUP_PULSE(WAKE), .SUPPLY_FROM_FIELD(SUPPLY), .FIELD_LOAD_EN(LOAD),
    .AUTO_SWITCH_EN(AUTO), .MOD_MODE(MOD_MODE), .DAMP_OUT(), .RECOVERED_CARRIER_CLOCK(), .BUSY(BUSY));
  tsi_host_model host (.clk(CLK), .sda_oe(SDA_OE), .scl(SCL), .sda(SDA_IN));
  // random carrier and damping levels
  always @(negedge CLK) begin
    CARRIER_IN <= 1'($urandom);
    DAMPING_CONTROL_IN <= 1'($urandom);
  end
  task automatic chk_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expected byte n of a read from row a
  function automatic logic [7:0] eb(input logic [4:0] a, input logic hi, input int n);
    logic [4:0] x;
    x = hi ? a - 5'(n / 2) : a + 5'(n / 2);
    return ((n % 2 == 0) == hi) ? mem[x][15:8] : mem[x][7:0];
  endfunction
  // write n data bytes and track the store
  task automatic wr(input logic [7:0] c, input int n);
    logic [15:0] w;
    w = mem[c[7:3]];
    host.start;
    host.wbyte(c, ack);
    chk_bit("write ctrl ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      host.wbyte(d[i], ack);
      chk_bit("data ack", i < 2, ack);
    end
    host.stop;
    chk_bit("standby oe", 1'b0, SDA_OE);
    if (c[2]) w = {d[0], n > 1 ? d[1] : w[7:0]};
    else w = {n > 1 ? d[1] : w[15:8], d[0]};
    mem[c[7:3]] = w;
  endtask
  // busy refuses a poll, then must finish in time
  task automatic settle;
    chk_bit("busy", 1'b1, BUSY);
    host.start;
    host.wbyte(8'h01, ack);
    host.stop;
    chk_bit("poll ack", 1'b0, ack);
    for (k = 0; k < 700 && BUSY !== 1'b0; k++) @(negedge CLK);
    if (k == 700) begin
      err_count++;
      close_out;
    end
  endtask
  // read n bytes, nack the last, then the device must stay silent
  task automatic rd(input logic [7:0] c, input int n);
    host.start;
    host.wbyte(c, ack);
    chk_bit("read ctrl ack", 1'b1, ack);
    for (int i = 0; i < n; i++) begin
      host.rbyte(b, i == n - 1);
      chk_byte("read data", eb(c[7:3], c[2], i), b);
    end
    host.rbyte(b, 1'b1);
    chk_byte("after nack", 8'hff, b);
    host.stop;
  endtask
  // apply and remove a field
  task automatic field(input logic auto);
    logic seen;
    COIL_BELOW_OFF_IN = 1'b0;
    COIL_ABOVE_ON_IN = 1'b1;
    FIELD_DETECT_IN = 1'b1;
    repeat (10) @(negedge CLK);
    COIL_ABOVE_ON_IN = 1'b0; // glitch shorter than the delay
    repeat (10) @(negedge CLK);
    chk_bit("glitch supply", 1'b0, SUPPLY);
    chk_bit("field out high", 1'b1, PRESENT);
    COIL_ABOVE_ON_IN = 1'b1;
    seen = 1'b0;
    for (k = 0; k < 60 && SUPPLY !== 1'b1; k++) begin
      @(negedge CLK);
      seen |= WAKE;
    end
    seen |= WAKE;
    @(negedge CLK);
    seen |= WAKE;
    chk_bit("supply", auto, SUPPLY);
    chk_bit("switch delay", 1'b1, k >= 20);
    chk_bit("wake", auto, seen);
    chk_bit("field load", auto, LOAD);
    COIL_ABOVE_ON_IN = 1'b0;
    COIL_BELOW_OFF_IN = 1'b1;
    FIELD_DETECT_IN = 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(negedge CLK);
      seen |= RST_OE;
    end
    chk_bit("loss reset", auto, seen);
    chk_bit("battery", 1'b0, SUPPLY);
    chk_bit("field out low", 1'b0, PRESENT);
    repeat (20) @(negedge CLK);
  endtask
  initial begin
    void'($urandom(32'h0a95b28b));
    {FIELD_DETECT_IN, COIL_ABOVE_ON_IN, COIL_BELOW_OFF_IN, CARRIER_IN, DAMPING_CONTROL_IN} = 5'h00;
    repeat (8) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    chk_bit("auto after reset", 1'b1, AUTO);
    chk_bit("oe after reset", 1'b0, SDA_OE);
    // store traffic, row zero first for the wrap
    for (t = 0; t < 4; t++) begin
      r = (t == 0) ? 5'h00 : 5'($urandom);
      for (j = 0; j < 3; j++) d[j] = 8'($urandom);
      wr({r, 1'b0, 1'($urandom), 1'b0}, 3);
      settle;
      for (j = 0; j < 3; j++) d[j] = 8'($urandom);
      wr({r - 5'h01, 3'b100}, 2);
      settle;
      rd({r, 3'b101}, 4);
      rd({r - 5'h01, 3'b001}, 4);
      d[0] = 8'($urandom);
      wr({r, 3'b100}, 1);
      settle;
      rd({r, 3'b101}, 2);
      $display("store test %0d done", t);
    end
    // special codes, spare bit random
    for (j = 0; j < 4; j++) begin
      host.start;
      host.wbyte(sp[j] | 8'(($urandom % 2) << 3), ack);
      host.stop;
      chk_bit("special ack", 1'b1, ack);
      if (j < 2) chk_byte("mod mode", 8'(j + 1), {6'h00, MOD_MODE});
      chk_bit("auto switch", j != 2, AUTO);
      if (j == 2) field(1'b0);
    end
    $display("special test done");
    field(1'b1);
    $display("field test done");
    close_out;
  end
endmodule // tsi_top_tb
